// file: afc_ctrl.sv
// afc_ctrl: drives the strobes of a strobe-driven 9-bit fifo from software commands
// assumes flag pins are asynchronous to core_clk; data bus pins read only while read is low
`timescale 1ns/1ps
module afc_ctrl #(
  parameter int unsigned DEPTH   = 512,
  parameter int unsigned CHAIN_N = 1
) (
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  input  wire logic [3:0]                    reg_addr,
  input  wire logic [15:0]                   reg_wdata,
  input  wire logic                          reg_write,
  input  wire logic                          reg_read,
  output logic      [15:0]                   reg_rdata,
  output afc_pkg::afc_pins_t                 pins,
  output logic                               write_data_oe,
  output logic                               first_loaded_n,
  output logic                               chain_in_n,
  input  wire logic [CHAIN_N-1:0]            empty_flag_n,
  input  wire logic [CHAIN_N-1:0]            full_flag_n,
  input  wire logic                          half_full_flag_n,
  input  wire logic [afc_pkg::WORD_W-1:0]    read_data_out
);
  localparam int unsigned CW = afc_pkg::CNT_W;
  localparam int unsigned WCW = $clog2(DEPTH) + 2;
  localparam int unsigned NFLAG = 3;

  afc_pkg::afc_act_t                 act;
  logic [CW-1:0]                     cnt;
  logic                              in_pulse;
  logic                              depth_mode;
  logic [afc_pkg::WORD_W-1:0]        wdata;
  logic [afc_pkg::WORD_W-1:0]        rdata;
  logic                              rvalid;
  logic                              refused;
  logic [WCW-1:0]                    wcount;
  logic [NFLAG-1:0]                  flag_raw;
  logic [NFLAG-1:0]                  flag_seen;
  logic                              any_empty;
  logic                              any_full;
  logic                              is_empty;
  logic                              is_full;
  logic                              is_half;
  logic                              busy;
  logic                              rewind_ok;
  logic                              cmd_wr;
  logic                              want_reset;
  logic                              want_write;
  logic                              want_read;
  logic                              want_rewind;

  // composite flags across a depth chain: any low flag counts
  assign any_empty = ~&empty_flag_n;
  assign any_full  = ~&full_flag_n;

  // flags active high: empty, full, half
  assign flag_raw = {~half_full_flag_n, any_full, any_empty};

  // three-stage sync per flag; a level counts once stages two and three agree
  for (genvar g = 0; g < NFLAG; g++) begin : g_flag_sync
    logic [2:0] stage;
    always_ff @(posedge core_clk) begin
      if (!reset_n) begin
        stage        <= {3{afc_pkg::FLAG_RST[g]}};
        flag_seen[g] <= afc_pkg::FLAG_RST[g];
      end else begin
        stage <= {stage[1:0], flag_raw[g]};
        if (stage[1] == stage[2])
          flag_seen[g] <= stage[1];
      end
    end
  end

  assign is_empty = flag_seen[0];
  assign is_full  = flag_seen[1];
  // the half pin carries the chain output in a depth ring, so it is masked there
  assign is_half  = flag_seen[2] & ~depth_mode;

  assign busy      = (act != afc_pkg::ACT_NONE);
  // rewind only while writes since reset fit the memory, and never in a depth chain
  assign rewind_ok = ~depth_mode && (wcount <= WCW'(DEPTH));
  assign cmd_wr    = reg_write && (reg_addr == afc_pkg::REG_CMD);
  assign want_reset  = cmd_wr && reg_wdata[afc_pkg::CMD_RESET];
  assign want_write  = cmd_wr && reg_wdata[afc_pkg::CMD_WRITE];
  assign want_read   = cmd_wr && reg_wdata[afc_pkg::CMD_READ];
  assign want_rewind = cmd_wr && reg_wdata[afc_pkg::CMD_REWIND];

  // sequencer: strobe low phase, then recovery plus flag settle with all strobes high
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      act      <= afc_pkg::ACT_NONE;
      cnt      <= '0;
      in_pulse <= 1'b0;
    end else if (!busy) begin
      in_pulse <= 1'b1;
      cnt      <= CW'(afc_pkg::PULSE_CYC);
      if (want_reset)
        act <= afc_pkg::ACT_RESET;
      else if (want_rewind && rewind_ok)
        act <= afc_pkg::ACT_REWIND;
      else if (want_read && !is_empty)
        act <= afc_pkg::ACT_READ;
      else if (want_write && !is_full)
        act <= afc_pkg::ACT_WRITE;
      else
        in_pulse <= 1'b0;
      if (want_write && !want_reset && !want_rewind && !want_read && !is_full)
        cnt <= CW'(afc_pkg::PULSE_CYC + afc_pkg::SETUP_CYC);
    end else if (cnt > CW'(1)) begin
      cnt <= cnt - CW'(1);
    end else if (in_pulse) begin
      in_pulse <= 1'b0;
      // flag settle covers recovery and lets the three-stage sync catch up
      cnt <= CW'(afc_pkg::RECOV_CYC + afc_pkg::FLAG_CYC + afc_pkg::SYNC_CYC);
    end else begin
      act <= afc_pkg::ACT_NONE;
    end
  end

  // strobes are registered; rewind keeps read and write high throughout
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pins.master_reset_n <= 1'b1;
      pins.rewind_n       <= 1'b1;
      pins.read_n         <= 1'b1;
      pins.write_n        <= 1'b1;
      pins.write_data_in  <= '0;
    end else begin
      pins.master_reset_n <= ~(in_pulse && act == afc_pkg::ACT_RESET);
      pins.rewind_n       <= ~(in_pulse && act == afc_pkg::ACT_REWIND);
      // one strobe set fans out to every device of a width group
      pins.read_n         <= ~(in_pulse && act == afc_pkg::ACT_READ);
      // data word only changes while idle, so it is settled long before write falls
      pins.write_data_in  <= wdata;
      // write low only after data has had its setup time on the bus
      pins.write_n        <= ~(in_pulse && act == afc_pkg::ACT_WRITE && cnt <= CW'(afc_pkg::PULSE_CYC));
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wdata         <= '0;
      write_data_oe <= 1'b0;
    end else begin
      if (reg_write && reg_addr == afc_pkg::REG_WDATA && !busy)
        wdata <= reg_wdata[afc_pkg::WORD_W-1:0];
      write_data_oe <= (act == afc_pkg::ACT_WRITE);
    end
  end
  // chain straps: standalone ties chain input low and first-load high
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      depth_mode     <= 1'b0;
      first_loaded_n <= 1'b1;
      chain_in_n     <= 1'b0;
    end else if (reg_write && reg_addr == afc_pkg::REG_CONFIG && !busy) begin
      depth_mode     <= reg_wdata[afc_pkg::CFG_DEPTH_MODE];
      // in a depth chain this controller marks its own device as first loaded
      first_loaded_n <= ~reg_wdata[afc_pkg::CFG_DEPTH_MODE];
      chain_in_n     <= 1'b0;
    end
  end

  // read data is taken on the edge that raises read: access time has passed and data still holds
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdata  <= '0;
      rvalid <= 1'b0;
    end else if (act == afc_pkg::ACT_READ && !in_pulse && !pins.read_n) begin
      rdata  <= read_data_out;
      rvalid <= 1'b1;
    end else if (reg_read && reg_addr == afc_pkg::REG_RDATA) begin
      rvalid <= 1'b0;
    end
  end

  // refusal is sticky; a new refusal in the clearing cycle wins
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      refused <= 1'b0;
    else if (cmd_wr && (busy || (want_read && is_empty) || (want_write && is_full)
                        || (want_rewind && !rewind_ok)))
      refused <= 1'b1;
    else if (reg_read && reg_addr == afc_pkg::REG_STATUS)
      refused <= 1'b0;
  end

  // writes since the last master reset, saturating
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      wcount <= '0;
    else if (act == afc_pkg::ACT_RESET)
      wcount <= '0;
    else if (act == afc_pkg::ACT_WRITE && in_pulse && cnt == CW'(1) && !(&wcount))
      wcount <= wcount + WCW'(1);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      case (reg_addr)
        afc_pkg::REG_RDATA:  reg_rdata <= 16'(rdata);
        afc_pkg::REG_WDATA:  reg_rdata <= 16'(wdata);
        afc_pkg::REG_STATUS: begin
          reg_rdata <= '0;
          reg_rdata[afc_pkg::ST_BUSY]      <= busy;
          reg_rdata[afc_pkg::ST_EMPTY]     <= is_empty;
          reg_rdata[afc_pkg::ST_HALF]      <= is_half;
          reg_rdata[afc_pkg::ST_FULL]      <= is_full;
          reg_rdata[afc_pkg::ST_REFUSED]   <= refused;
          reg_rdata[afc_pkg::ST_RVALID]    <= rvalid;
          reg_rdata[afc_pkg::ST_REWIND_OK] <= rewind_ok;
        end
        afc_pkg::REG_CONFIG: reg_rdata <= 16'(depth_mode);
        afc_pkg::REG_WCOUNT: reg_rdata <= 16'(wcount);
        default:             reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : afc_ctrl

// file: afc_ctrl_properties.sv
// afc_ctrl_properties: port-level assertions on the fifo strobe controller
// assumes one core clock domain; bound to every afc_ctrl instance below
`timescale 1ns/1ps
module afc_ctrl_chk #(
  parameter int unsigned DEPTH   = 512,
  parameter int unsigned CHAIN_N = 1
) (
  input logic               core_clk,
  input logic               reset_n,
  input logic               reg_read,
  input logic [15:0]        reg_rdata,
  input afc_pkg::afc_pins_t pins,
  input logic               write_data_oe,
  input logic               first_loaded_n,
  input logic               chain_in_n,
  input logic [CHAIN_N-1:0] empty_flag_n,
  input logic [CHAIN_N-1:0] full_flag_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  int unsigned wcnt;
  // write pulses since the last master reset; saturates just past depth
  always_ff @(posedge core_clk) begin
    if (!reset_n || !pins.master_reset_n) wcnt <= 0;
    else if ($fell(pins.write_n) && wcnt <= DEPTH) wcnt <= wcnt + 1;
  end
  chk_rewind_quiet: assert property (!pins.rewind_n |-> pins.read_n && pins.write_n)
    else $error("strobe low during rewind");
  chk_rewind_recov: assert property ($rose(pins.rewind_n) |-> (pins.read_n && pins.write_n) [*2])
    else $error("strobe low in rewind recovery");
  chk_rewind_allowed: assert property ($fell(pins.rewind_n) |-> wcnt <= DEPTH && first_loaded_n)
    else $error("rewind issued when not allowed");
  chk_read_gated: assert property ((~&empty_flag_n) [*6] |=> !$fell(pins.read_n))
    else $error("read started on empty fifo");
  chk_write_gated: assert property ((~&full_flag_n) [*8] |=> !$fell(pins.write_n))
    else $error("write started on full fifo");
  chk_straps_fixed: assert property (!chain_in_n)
    else $error("chain input strap not low");
  chk_read_pulse: assert property ($fell(pins.read_n) |-> !pins.read_n [*3] ##1 pins.read_n)
    else $error("read pulse length wrong");
  chk_write_pulse: assert property ($fell(pins.write_n) |-> $past(write_data_oe, 2)
    ##0 (!pins.write_n && write_data_oe && $stable(pins.write_data_in)) [*3] ##1 pins.write_n)
    else $error("write pulse or data setup wrong");
  chk_reset_quiet: assert property (!pins.master_reset_n || !$past(pins.master_reset_n)
    |-> pins.read_n && pins.write_n)
    else $error("strobe low around master reset");
  chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0)
    else $error("read data not zero outside read answer");
endmodule : afc_ctrl_chk
bind afc_ctrl afc_ctrl_chk #(.DEPTH(DEPTH), .CHAIN_N(CHAIN_N)) u_chk (.core_clk, .reset_n, .reg_read,
  .reg_rdata, .pins, .write_data_oe, .first_loaded_n, .chain_in_n, .empty_flag_n, .full_flag_n);

// file: afc_ctrl_tb_top.sv
// afc_ctrl_tb_top: self-checking bench, controller driving the behavioural fifo
// assumes afc_pkg, afc_ctrl, the checker and afc_fifo_model are compiled first
`timescale 1ns/1ps
module afc_ctrl_tb_top;
  localparam int unsigned DEPTH = 8; // small depth keeps fill and rewind short
  logic               core_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, rf;
  logic [3:0]         reg_addr = 4'h0;
  logic [15:0]        reg_wdata = 16'h0, reg_rdata, d;
  afc_pkg::afc_pins_t pins;
  logic               write_data_oe, first_loaded_n, chain_in_n, empty_flag_n, full_flag_n, half_full_flag_n;
  logic [8:0]         read_data_out;
  int                 n_errors = 0, n_tests = 0, cycles = 0;
  always #12.5 core_clk = ~core_clk;
  afc_ctrl #(.DEPTH(DEPTH), .CHAIN_N(1)) DUT (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .pins, .write_data_oe, .first_loaded_n, .chain_in_n, .empty_flag_n,
    .full_flag_n, .half_full_flag_n, .read_data_out);
  afc_fifo_model #(.DEPTH(DEPTH)) u_fifo (.pins, .chain_in_n, .first_loaded_n, .empty_flag_n,
    .full_flag_n, .half_full_flag_n, .read_data_out);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
  // polling clears the sticky refusal, so it is gathered here
  task automatic op(input int b);
    int i;
    wr(afc_pkg::REG_CMD, 16'h1 << b);
    rf = 1'b0;
    for (i = 0; i < 40; i++) begin
      rd(afc_pkg::REG_STATUS);
      rf = rf | d[afc_pkg::ST_REFUSED];
      if (d[afc_pkg::ST_BUSY] === 1'b0) break;
    end
  endtask : op
  task automatic push(input logic [15:0] v);
    wr(afc_pkg::REG_WDATA, v);
    op(afc_pkg::CMD_WRITE);
  endtask : push
  task automatic pop;
    op(afc_pkg::CMD_READ);
    rd(afc_pkg::REG_RDATA);
  endtask : pop
  task automatic flags(input logic e, input logic h, input logic f);
    rd(afc_pkg::REG_STATUS);
    check({13'h0, d[3:1]}, {13'h0, f, h, e});
  endtask : flags
  task automatic t_reset;
    rd(4'hf);
    check(d, 16'h0);
    op(afc_pkg::CMD_RESET);
    flags(1'b1, 1'b0, 1'b0);
    op(afc_pkg::CMD_READ);
    check({15'h0, rf}, 16'h1);
  endtask : t_reset
  task automatic t_fill;
    int i;
    for (i = 0; i < DEPTH; i++) begin
      push(16'h100 + 16'(i));
      flags(1'b0, i >= DEPTH / 2, i == DEPTH - 1);
    end
    push(16'h0aa);
    check({15'h0, rf}, 16'h1);
    pop;
    check(d, 16'h100);
    flags(1'b0, 1'b1, 1'b0);
  endtask : t_fill
  task automatic t_rewind;
    int i;
    op(afc_pkg::CMD_REWIND);
    check({15'h0, rf}, 16'h0);
    flags(1'b0, 1'b1, 1'b1);
    for (i = 0; i < DEPTH; i++) begin
      pop;
      check(d, 16'h100 + 16'(i));
    end
    flags(1'b1, 1'b0, 1'b0);
    push(16'h055);
    pop;
    check(d, 16'h055);
    op(afc_pkg::CMD_REWIND);
    check({15'h0, rf}, 16'h1);
  endtask : t_rewind
  task automatic t_depth;
    // strap first, so the fifo sees first-load low during its master reset
    wr(afc_pkg::REG_CONFIG, 16'h1);
    op(afc_pkg::CMD_RESET);
    repeat (2) @(negedge core_clk);
    check({15'h0, first_loaded_n}, 16'h0);
    push(16'h011);
    op(afc_pkg::CMD_REWIND);
    check({15'h0, rf}, 16'h1);
  endtask : t_depth
  task automatic conclude;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset;
    t_fill;
    t_rewind;
    t_depth;
    conclude;
  end
  // ceiling well above the few hundred cycles the scenarios need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude;
    end
  end
endmodule : afc_ctrl_tb_top

// file: afc_fifo_model.sv
// afc_fifo_model: behavioural strobe-driven 9-bit fifo at the controller's pins
// assumes a single device, standalone unless first_loaded_n is low
`timescale 1ns/1ps
module afc_fifo_model #(
  parameter int unsigned DEPTH = 8
) (
  input  afc_pkg::afc_pins_t pins,
  input  logic               chain_in_n,
  input  logic               first_loaded_n,
  output logic               empty_flag_n,
  output logic               full_flag_n,
  output logic               half_full_flag_n,
  output logic [8:0]         read_data_out
);
  logic [8:0]  mem [DEPTH];
  logic        depth = 1'b0, chain_n = 1'b1;
  int unsigned wp = 0, rp = 0, cnt = 0, nw = 0, ra;
  // flags lag as late as allowed so early sampling by the controller shows up
  assign #(afc_pkg::T_FLAG_NS) empty_flag_n = (cnt != 0);
  assign #(afc_pkg::T_FLAG_NS) full_flag_n = (cnt != DEPTH);
  // in a depth ring the half pin carries the chain output instead
  assign #(afc_pkg::T_FLAG_NS) half_full_flag_n = depth ? chain_n : (cnt <= DEPTH / 2);
  always @(negedge pins.master_reset_n) begin
    wp = 0;
    rp = 0;
    cnt = 0;
    nw = 0;
    read_data_out = 9'h1ff;
    // a lone device strapped first-loaded is its own ring and holds both enables
    depth = !first_loaded_n;
  end
  always @(posedge pins.write_n) if (pins.master_reset_n && cnt < DEPTH) begin
    mem[wp] = pins.write_data_in;
    wp = (wp + 1) % DEPTH;
    cnt++;
    nw++;
    if (depth && wp == 0) begin
      chain_n = 1'b0;
      #(afc_pkg::T_PULSE_NS) chain_n = 1'b1;
    end
  end
  always @(negedge pins.read_n) if (cnt != 0) begin
    ra = rp;
    rp = (rp + 1) % DEPTH;
    cnt--;
    read_data_out = ~mem[ra];
    #(afc_pkg::T_ACCESS_NS) read_data_out = mem[ra];
    if (depth && rp == 0) begin
      chain_n = 1'b0;
      #(afc_pkg::T_PULSE_NS) chain_n = 1'b1;
    end
  end
  // released bus shows the inverse, so a late sample cannot pass by luck
  always @(posedge pins.read_n) read_data_out = ~read_data_out;
  always @(negedge pins.rewind_n) if (!chain_in_n && first_loaded_n && !depth) begin
    rp = 0;
    cnt = (nw > DEPTH) ? DEPTH : nw;
  end
endmodule : afc_fifo_model

// file: afc_pkg.sv
// afc_pkg: constants and carriers for the host-side controller of a 9-bit strobe-driven fifo
// assumes a 40 MHz core clock; pin timing figures are the slowest grade in nanoseconds
package afc_pkg;
  localparam int unsigned CLK_NS        = 25;
  localparam int unsigned WORD_W        = 9;
  // pulse widths and recoveries, ns
  localparam int unsigned T_PULSE_NS    = 65;   // read, write, reset, rewind low time
  localparam int unsigned T_RECOV_NS    = 15;   // recovery after each strobe
  localparam int unsigned T_FLAG_NS     = 60;   // strobe edge to flag valid
  localparam int unsigned T_ACCESS_NS   = 65;   // read low to data valid
  localparam int unsigned T_SETUP_NS    = 30;   // data setup before write rising edge
  // cycle counts, least times rounded up
  localparam int unsigned PULSE_CYC     = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RECOV_CYC     = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned FLAG_CYC      = (T_FLAG_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ACCESS_CYC    = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SETUP_CYC     = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W         = 4;
  localparam int unsigned SYNC_CYC      = 3;    // flag synchroniser depth
  // flag reset levels, bit 0 empty, 1 full, 2 half: empty assumed until the pins settle
  localparam logic [2:0]  FLAG_RST      = 3'h1;
  // software register map, word offsets on the plain port
  localparam logic [3:0] REG_CMD        = 4'h0;
  localparam logic [3:0] REG_WDATA      = 4'h1;
  localparam logic [3:0] REG_RDATA      = 4'h2;
  localparam logic [3:0] REG_STATUS     = 4'h3;
  localparam logic [3:0] REG_CONFIG     = 4'h4;
  localparam logic [3:0] REG_WCOUNT     = 4'h5;
  // command bits
  localparam int unsigned CMD_RESET     = 0;
  localparam int unsigned CMD_WRITE     = 1;
  localparam int unsigned CMD_READ      = 2;
  localparam int unsigned CMD_REWIND    = 3;
  // status bits
  localparam int unsigned ST_BUSY       = 0;
  localparam int unsigned ST_EMPTY      = 1;
  localparam int unsigned ST_HALF       = 2;
  localparam int unsigned ST_FULL       = 3;
  localparam int unsigned ST_REFUSED    = 4;
  localparam int unsigned ST_RVALID     = 5;
  localparam int unsigned ST_REWIND_OK  = 6;
  localparam int unsigned CFG_DEPTH_MODE = 0;
  typedef struct packed {
    logic              write_n;
    logic              read_n;
    logic              rewind_n;
    logic              master_reset_n;
    logic [WORD_W-1:0] write_data_in;
  } afc_pins_t;
  typedef struct packed {
    logic empty_flag_n;
    logic half_full_flag_n;
    logic full_flag_n;
  } afc_flags_t;
  typedef enum logic [2:0] {
    ACT_NONE,
    ACT_RESET,
    ACT_WRITE,
    ACT_READ,
    ACT_REWIND
  } afc_act_t;
endpackage : afc_pkg
